// ---- cfgio_regs.svh ----
// Purpose: Offsets, field positions, reset values and encodings of the I/O port
// Assumes: Byte-wide registers on a 4-bit register address
// Notes:   Pin index order is P0.4, P0.5, P1.2, reset pin, P3.0, P3.1
`ifndef CFGIO_REGS_SVH
`define CFGIO_REGS_SVH

`define CFGIO_OFS_P0_DATA   4'h0
`define CFGIO_OFS_P0_CFG1   4'h1
`define CFGIO_OFS_P0_CFG2   4'h2
`define CFGIO_OFS_P1_DATA   4'h3
`define CFGIO_OFS_P1_CFG1   4'h4
`define CFGIO_OFS_P1_CFG2   4'h5
`define CFGIO_OFS_P3_DATA   4'h6
`define CFGIO_OFS_P3_CFG1   4'h7
`define CFGIO_OFS_P3_CFG2   4'h8
`define CFGIO_OFS_P0_DIS    4'h9
`define CFGIO_OFS_UCFG      4'hA
`define CFGIO_OFS_STATUS    4'hB

`define CFGIO_RST_LATCH     8'hFF
`define CFGIO_RST_CFG1      8'hFF
`define CFGIO_RST_CFG2      8'h00
`define CFGIO_RST_DIS       8'h00
`define CFGIO_RST_UCFG      8'h01

`define CFGIO_P0_MASK       8'h30
`define CFGIO_P1_MASK       8'h24
`define CFGIO_P3_MASK       8'h03

`define CFGIO_UCFG_RSTEN_BIT 0
`define CFGIO_NPINS         6
`define CFGIO_RSTPIN_IDX    3
`define CFGIO_IO_WITH_RST   3'h5
`define CFGIO_IO_NO_RST     3'h6

`endif

// ---- cfgio_pkg.sv ----
// Purpose: Types shared by the configurable I/O port
// Assumes: Two configuration bits per pin, first bit high-order
// Notes:   Codes follow the pair {cfg1, cfg2}
package cfgio_pkg;

    typedef enum logic [1:0] {
        CFGIO_QUASI = 2'b00,
        CFGIO_PUSH  = 2'b01,
        CFGIO_INPUT = 2'b10,
        CFGIO_OPEN  = 2'b11
    } cfgio_drv_t;

endpackage : cfgio_pkg

// ---- cfgio_sync.sv ----
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module cfgio_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // Pins idle high on their pull-ups; avoids a false low after reset
            meta_r <= '1;
            q      <= '1;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : cfgio_sync

// ---- cfgio_port.sv ----
// Purpose: Per-pin configurable driver logic and registers for a six-pin port
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Pad drivers sit outside; this block drives their enables
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "cfgio_regs.svh"

module cfgio_port (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       power_up,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [5:0] pin_in,
    output logic      [5:0] pin_out,
    output logic      [5:0] pin_oe,
    output logic      [5:0] pin_weak_pu,
    output logic            ext_reset_req,
    output logic      [2:0] io_pin_count
);
    logic [7:0] p0_latch_r;
    logic [7:0] p0_cfg1_r;
    logic [7:0] p0_cfg2_r;
    logic [7:0] p1_latch_r;
    logic [7:0] p1_cfg1_r;
    logic [7:0] p1_cfg2_r;
    logic [7:0] p3_latch_r;
    logic [7:0] p3_cfg1_r;
    logic [7:0] p3_cfg2_r;
    logic [7:0] port0_digital_input_disable_r;
    logic [7:0] user_config_byte_one_r;
    logic [5:0] pin_s;
    logic [5:0] latch6;
    logic [5:0] cfg1_6;
    logic [5:0] cfg2_6;
    logic [5:0] out_nxt;
    logic [5:0] oe_nxt;
    logic [5:0] pu_nxt;
    logic [5:0] din;
    logic [7:0] rd_nxt;
    logic       reset_pin_function_enable;
    logic       ext_reset_nxt;
    logic [2:0] io_cnt_nxt;
    cfgio_pkg::cfgio_drv_t mode6 [6];

    cfgio_sync #(
        .W (`CFGIO_NPINS)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (pin_in),
        .q   (pin_s)
    );

    wire sel_p0d = (reg_addr == `CFGIO_OFS_P0_DATA);
    wire sel_p0a = (reg_addr == `CFGIO_OFS_P0_CFG1);
    wire sel_p0b = (reg_addr == `CFGIO_OFS_P0_CFG2);
    wire sel_p1d = (reg_addr == `CFGIO_OFS_P1_DATA);
    wire sel_p1a = (reg_addr == `CFGIO_OFS_P1_CFG1);
    wire sel_p1b = (reg_addr == `CFGIO_OFS_P1_CFG2);
    wire sel_p3d = (reg_addr == `CFGIO_OFS_P3_DATA);
    wire sel_p3a = (reg_addr == `CFGIO_OFS_P3_CFG1);
    wire sel_p3b = (reg_addr == `CFGIO_OFS_P3_CFG2);
    wire sel_dis = (reg_addr == `CFGIO_OFS_P0_DIS);
    wire sel_ucf = (reg_addr == `CFGIO_OFS_UCFG);
    wire sel_sts = (reg_addr == `CFGIO_OFS_STATUS);

    // Whole bytes are stored except the input disable, which is masked on write; unused config bits are masked on read, but the user config byte reads back whole
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            p0_latch_r <= `CFGIO_RST_LATCH;
            p1_latch_r <= `CFGIO_RST_LATCH;
            p3_latch_r <= `CFGIO_RST_LATCH;
        end
        else if (reg_wr)
        begin
            if (sel_p0d) p0_latch_r <= reg_wdata;
            if (sel_p1d) p1_latch_r <= reg_wdata;
            if (sel_p3d) p3_latch_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            p0_cfg1_r <= `CFGIO_RST_CFG1;
            p0_cfg2_r <= `CFGIO_RST_CFG2;
            p1_cfg1_r <= `CFGIO_RST_CFG1;
            p1_cfg2_r <= `CFGIO_RST_CFG2;
            p3_cfg1_r <= `CFGIO_RST_CFG1;
            p3_cfg2_r <= `CFGIO_RST_CFG2;
        end
        else if (reg_wr)
        begin
            if (sel_p0a) p0_cfg1_r <= reg_wdata;
            if (sel_p0b) p0_cfg2_r <= reg_wdata;
            if (sel_p1a) p1_cfg1_r <= reg_wdata;
            if (sel_p1b) p1_cfg2_r <= reg_wdata;
            if (sel_p3a) p3_cfg1_r <= reg_wdata;
            if (sel_p3b) p3_cfg2_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            port0_digital_input_disable_r <= `CFGIO_RST_DIS;
            user_config_byte_one_r        <= `CFGIO_RST_UCFG;
        end
        else if (reg_wr)
        begin
            if (sel_dis) port0_digital_input_disable_r <= reg_wdata & `CFGIO_P0_MASK;
            if (sel_ucf) user_config_byte_one_r <= reg_wdata;
        end
    end

    assign reset_pin_function_enable = user_config_byte_one_r[`CFGIO_UCFG_RSTEN_BIT];

    // Gather the six pins out of the three byte-wide ports
    assign latch6 = {p3_latch_r[1], p3_latch_r[0], p1_latch_r[5],
                     p1_latch_r[2], p0_latch_r[5], p0_latch_r[4]};
    assign cfg1_6 = {p3_cfg1_r[1], p3_cfg1_r[0], p1_cfg1_r[5],
                     p1_cfg1_r[2], p0_cfg1_r[5], p0_cfg1_r[4]};
    assign cfg2_6 = {p3_cfg2_r[1], p3_cfg2_r[0], p1_cfg2_r[5],
                     p1_cfg2_r[2], p0_cfg2_r[5], p0_cfg2_r[4]};

    // Digital input path; port 0 pins can be cut off for analog use
    assign din = pin_s & ~{4'h0, port0_digital_input_disable_r[5],
                           port0_digital_input_disable_r[4]};

    genvar gi;
    generate
        for (gi = 0; gi < `CFGIO_NPINS; gi++)
        begin : g_pin
            if (gi == `CFGIO_RSTPIN_IDX)
            begin : g_rst
                // Reset pin has no output structure at all
                assign mode6[gi]   = cfgio_pkg::CFGIO_INPUT;
                assign out_nxt[gi] = 1'b0;
                assign oe_nxt[gi]  = 1'b0;
                assign pu_nxt[gi]  = 1'b0;
            end
            else
            begin : g_io
                logic out_c;
                logic oe_c;
                logic pu_c;
                assign mode6[gi] = cfgio_pkg::cfgio_drv_t'({cfg1_6[gi], cfg2_6[gi]});
                always_comb
                begin
                    out_c = 1'b0;
                    oe_c  = 1'b0;
                    pu_c  = 1'b0;
                    case (mode6[gi])
                        cfgio_pkg::CFGIO_QUASI:
                        begin
                            oe_c = ~latch6[gi];
                            pu_c = latch6[gi];
                        end
                        cfgio_pkg::CFGIO_PUSH:
                        begin
                            out_c = latch6[gi];
                            oe_c  = 1'b1;
                        end
                        cfgio_pkg::CFGIO_OPEN:
                        begin
                            oe_c = ~latch6[gi];
                        end
                        cfgio_pkg::CFGIO_INPUT:
                        begin
                            oe_c = 1'b0;
                        end
                        default:
                        begin
                            oe_c = 1'b0;
                        end
                    endcase
                end
                // One continuous driver per bit of the shared vectors
                assign out_nxt[gi] = out_c;
                assign oe_nxt[gi]  = oe_c;
                assign pu_nxt[gi]  = pu_c;
            end
        end
    endgenerate

    // Pin acts as reset while enabled or during power-up
    assign ext_reset_nxt = ~pin_s[`CFGIO_RSTPIN_IDX]
                           & (reset_pin_function_enable | power_up);
    assign io_cnt_nxt = reset_pin_function_enable ? `CFGIO_IO_WITH_RST
                                                  : `CFGIO_IO_NO_RST;

    wire [7:0] p0_rd = {2'h0, din[1], din[0], 4'h0};
    wire [7:0] p1_rd = {2'h0, din[3], 2'h0, din[2], 2'h0};
    wire [7:0] p3_rd = {6'h00, din[5], din[4]};
    wire [7:0] st_rd = {2'h0, io_pin_count, power_up,
                        ext_reset_req, reset_pin_function_enable};

    always_comb
    begin
        rd_nxt = 8'h00;
        if (sel_p0d) rd_nxt = p0_rd;
        if (sel_p0a) rd_nxt = p0_cfg1_r & `CFGIO_P0_MASK;
        if (sel_p0b) rd_nxt = p0_cfg2_r & `CFGIO_P0_MASK;
        if (sel_p1d) rd_nxt = p1_rd;
        if (sel_p1a) rd_nxt = p1_cfg1_r & `CFGIO_P1_MASK;
        if (sel_p1b) rd_nxt = p1_cfg2_r & `CFGIO_P1_MASK;
        if (sel_p3d) rd_nxt = p3_rd;
        if (sel_p3a) rd_nxt = p3_cfg1_r & `CFGIO_P3_MASK;
        if (sel_p3b) rd_nxt = p3_cfg2_r & `CFGIO_P3_MASK;
        if (sel_dis) rd_nxt = port0_digital_input_disable_r;
        if (sel_ucf) rd_nxt = user_config_byte_one_r;
        if (sel_sts) rd_nxt = st_rd;
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rd_nxt;
        else
            reg_rdata <= 8'h00;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_out       <= 6'h00;
            pin_oe        <= 6'h00;
            pin_weak_pu   <= 6'h00;
            ext_reset_req <= 1'b0;
            io_pin_count  <= `CFGIO_IO_NO_RST;
        end
        else
        begin
            pin_out       <= out_nxt;
            pin_oe        <= oe_nxt;
            pin_weak_pu   <= pu_nxt;
            ext_reset_req <= ext_reset_nxt;
            io_pin_count  <= io_cnt_nxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_push0;
        mode6[0] == cfgio_pkg::CFGIO_PUSH;
    endsequence

    sequence s_open_hi0;
        (mode6[0] == cfgio_pkg::CFGIO_OPEN) && latch6[0];
    endsequence

    property p_rstpin_no_drive;
        pin_oe[`CFGIO_RSTPIN_IDX] == 1'b0 && pin_weak_pu[`CFGIO_RSTPIN_IDX] == 1'b0;
    endproperty
    a_rstpin_no_drive: assert property (p_rstpin_no_drive)
        else $error("reset pin driver enabled");

    property p_after_reset;
        @(posedge clk) rst |=> (pin_oe == 6'h00 && pin_weak_pu == 6'h00);
    endproperty
    a_after_reset: assert property (p_after_reset)
        else $error("drivers on after reset");

    property p_quasi;
        (mode6[0] == cfgio_pkg::CFGIO_QUASI)
            |=> (pin_weak_pu[0] == $past(latch6[0])) && (pin_oe[0] == !$past(latch6[0]))
                && !pin_out[0];
    endproperty
    a_quasi: assert property (p_quasi)
        else $error("quasi pin drive wrong");

    property p_open;
        s_open_hi0 |=> !pin_oe[0] && !pin_weak_pu[0];
    endproperty
    a_open: assert property (p_open)
        else $error("open-drain pin not floating");

    property p_input;
        (mode6[1] == cfgio_pkg::CFGIO_INPUT) |=> !pin_oe[1] && !pin_weak_pu[1];
    endproperty
    a_input: assert property (p_input)
        else $error("input-only pin driven");

    property p_push;
        s_push0 |=> pin_oe[0] && (pin_out[0] == $past(latch6[0]));
    endproperty
    a_push: assert property (p_push)
        else $error("push-pull pin wrong");

    property p_dis_clear;
        @(posedge clk) rst |=> port0_digital_input_disable_r == 8'h00;
    endproperty
    a_dis_clear: assert property (p_dis_clear)
        else $error("input disable not cleared");

    property p_count;
        !rst |=> io_pin_count == ($past(reset_pin_function_enable) ? `CFGIO_IO_WITH_RST
                                                                    : `CFGIO_IO_NO_RST);
    endproperty
    a_count: assert property (p_count)
        else $error("pin count wrong");

    property p_ext_reset;
        (!pin_s[`CFGIO_RSTPIN_IDX] && power_up) |=> ext_reset_req;
    endproperty
    a_ext_reset: assert property (p_ext_reset)
        else $error("power-up reset pin ignored");

    property p_ext_reset_off;
        (pin_s[`CFGIO_RSTPIN_IDX] || !(reset_pin_function_enable || power_up)) |=> !ext_reset_req;
    endproperty
    a_ext_reset_off: assert property (p_ext_reset_off)
        else $error("reset request without enabled low reset pin");

    property p_read_p3;
        (reg_rd && sel_p3d) |=> reg_rdata == {6'h00, $past(pin_s[5]), $past(pin_s[4])};
    endproperty
    a_read_p3: assert property (p_read_p3)
        else $error("port read wrong");

    property p_sync_delay;
        (!rst ##1 !rst) |=> pin_s == $past(pin_in, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("synchroniser depth wrong");

endmodule : cfgio_port

// ---- cfgio_load.sv ----
// Purpose: External circuits on the port pins
// Assumes: Every pin has an external pull-up resistor
// Notes:   A bench driver may pull any pin; a fight reads unknown
`timescale 1ns/1ps
module cfgio_load (
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_val,
    output logic      [5:0] pin_in
);
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (pin_oe[i] && ext_en[i] && (pin_out[i] != ext_val[i]))
                pin_in[i] = 1'bx;
            else if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else
                pin_in[i] = 1'b1;
        end
    end
endmodule : cfgio_load

// ---- tb_cfgio_port.sv ----
// Purpose: Self-checking bench for the configurable I/O port
// Assumes: Register map and mode codes of the design header and package
// Notes:   Pins pass through the load model back into the port
`timescale 1ns/1ps
`include "cfgio_regs.svh"
module tb_cfgio_port;
    logic       clk;
    logic       rst;
    logic       power_up;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [5:0] pin_in;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic [5:0] pin_weak_pu;
    logic       ext_reset_req;
    logic [2:0] io_pin_count;
    logic [5:0] ext_en;
    logic [5:0] ext_val;
    int         failures;
    int         tests_run;
    logic [2:0] exp3;
    logic [1:0] modes [4];

    cfgio_port u_cfgio_port (.clk(clk), .rst(rst), .power_up(power_up),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_weak_pu(pin_weak_pu), .ext_reset_req(ext_reset_req),
        .io_pin_count(io_pin_count));
    cfgio_load u_cfgio_load (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    always #2 clk = ~clk;

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic settle;
        repeat (5) @(posedge clk);
        #1;
    endtask : settle

    task automatic wait_req(input logic exp);
        int n;
        n = 0;
        while (ext_reset_req !== exp && n < 10)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h00, ext_reset_req}, {7'h00, exp});
        if (ext_reset_req !== exp)
            finish_test();
    endtask : wait_req

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        power_up = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ext_en = 6'h00;
        ext_val = 6'h00;
        failures = 0;
        tests_run = 0;
        modes = '{cfgio_pkg::CFGIO_QUASI, cfgio_pkg::CFGIO_PUSH,
                  cfgio_pkg::CFGIO_INPUT, cfgio_pkg::CFGIO_OPEN};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk({2'b00, pin_oe | pin_weak_pu}, 8'h00);
        rd(`CFGIO_OFS_P0_CFG1, 8'h30);
        @(posedge clk);
        #1;
        chk(reg_rdata, 8'h00);
        rd(`CFGIO_OFS_P1_CFG1, 8'h24);
        rd(`CFGIO_OFS_P3_CFG1, 8'h03);
        rd(`CFGIO_OFS_P3_CFG2, 8'h00);
        rd(`CFGIO_OFS_P0_DIS, 8'h00);
        rd(`CFGIO_OFS_P0_DATA, 8'h30);
        rd(`CFGIO_OFS_STATUS, 8'h29);
        rd(4'hC, 8'h00);
        $display("Test reset values done");
        for (int m = 0; m < 4; m++)
        begin
            wr(`CFGIO_OFS_P3_CFG1, {7'h00, modes[m][1]});
            wr(`CFGIO_OFS_P3_CFG2, {7'h00, modes[m][0]});
            for (int l = 0; l < 2; l++)
            begin
                wr(`CFGIO_OFS_P3_DATA, {6'h00, 1'b1, l[0]});
                settle();
                case (modes[m])
                    cfgio_pkg::CFGIO_QUASI: exp3 = l[0] ? 3'b001 : 3'b100;
                    cfgio_pkg::CFGIO_PUSH:  exp3 = {1'b1, l[0], 1'b0};
                    cfgio_pkg::CFGIO_OPEN:  exp3 = l[0] ? 3'b000 : 3'b100;
                    default:                exp3 = 3'b000;
                endcase
                chk({5'h00, pin_oe[4], pin_oe[4] & pin_out[4], pin_weak_pu[4]},
                    {5'h00, exp3});
                rd(`CFGIO_OFS_P3_DATA, {6'h00, 1'b1, ~(exp3[2] & ~exp3[1])});
            end
        end
        $display("Test driver types done");
        wr(`CFGIO_OFS_P3_CFG1, 8'h00);
        wr(`CFGIO_OFS_P3_CFG2, 8'h00);
        wr(`CFGIO_OFS_P3_DATA, 8'hFF);
        ext_en  <= 6'h10;
        ext_val <= 6'h00;
        settle();
        chk({7'h00, pin_oe[4]}, 8'h00);
        rd(`CFGIO_OFS_P3_DATA, 8'h02);
        ext_en <= 6'h00;
        $display("Test quasi pulled low done");
        wr(`CFGIO_OFS_P1_CFG1, 8'h00);
        wr(`CFGIO_OFS_P1_CFG2, 8'hFF);
        wr(`CFGIO_OFS_P1_DATA, 8'h00);
        settle();
        chk({5'h00, pin_oe[3], pin_weak_pu[3], pin_oe[2]}, 8'h01);
        rd(`CFGIO_OFS_P1_CFG2, 8'h24);
        rd(`CFGIO_OFS_P1_DATA, 8'h20);
        ext_en  <= 6'h08;
        ext_val <= 6'h00;
        wait_req(1'b1);
        rd(`CFGIO_OFS_STATUS, 8'h2B);
        wr(`CFGIO_OFS_UCFG, 8'h00);
        wait_req(1'b0);
        rd(`CFGIO_OFS_STATUS, 8'h30);
        rd(`CFGIO_OFS_P1_DATA, 8'h00);
        @(posedge clk);
        power_up <= 1'b1;
        wait_req(1'b1);
        @(posedge clk);
        power_up <= 1'b0;
        wait_req(1'b0);
        ext_en <= 6'h00;
        $display("Test reset pin done");
        wr(`CFGIO_OFS_P0_CFG1, 8'h30);
        wr(`CFGIO_OFS_P0_CFG2, 8'h00);
        wr(`CFGIO_OFS_P0_DIS, 8'h30);
        settle();
        rd(`CFGIO_OFS_P0_DIS, 8'h30);
        rd(`CFGIO_OFS_P0_DATA, 8'h00);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle();
        rd(`CFGIO_OFS_P0_DIS, 8'h00);
        rd(`CFGIO_OFS_P0_DATA, 8'h30);
        rd(`CFGIO_OFS_UCFG, 8'h01);
        chk({2'b00, pin_oe | pin_weak_pu}, 8'h00);
        $display("Test analog pin and second reset done");
        finish_test();
    end
endmodule : tb_cfgio_port
